// ### asce_pkg.sv
// Constants, register map and shared helpers of the serial control block.
// Assumes a 200 MHz aclk and an AXI4-Lite master with 32-bit data.
// How it works
// - Bit 7 set lets an empty transmit buffer raise the interrupt request.
// - Bit 6 set lets an idle transmitter raise the interrupt request.
// - Bit 5 set lets a full receive buffer raise the interrupt request.
// - Bit 4 set lets a detected idle line raise the interrupt request.
// - Bit 3 turns the transmitter on; it then owns the transmit pin.
// - Internal loopback releases the transmit pin even with the transmitter on.
// - In single-wire mode the direction bit decides drive or receive.
// - Turning the transmitter off then on queues one idle character.
// - The transmit pin is kept until data already in the shifter, queued idle or break finish.
// - Bit 2 turns the receiver on; off hands the receive pin back.
// - Bit 1 puts the receiver in standby awaiting its wakeup condition.
// - Wakeup is an idle line, or a character with its top bit set.
// - Software sets the standby bit; hardware clears it on wakeup.
// - Writing 1 then 0 to bit 0 queues one break character.
// - While bit 0 stays 1, break characters of all zeros keep coming.
// - A second break may be queued before software clears bit 0.
// - The control register is readable and writable at any time.
// - Loopback uses no pin; single-wire shares the transmit pin both ways.
// - The transmit buffer empty flag is set at reset and each time the shifter takes its data.
package asce_pkg;
  localparam int ADDR_W = 5;
  localparam int CNT_W  = 17;
  localparam logic [ADDR_W-1:0] OFS_CTL2  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_LINE  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_BAUD  = 5'h10;
  localparam logic [ADDR_W-1:0] WORD_MASK = 5'h1c;
  localparam int XMIT_EMPTY_IRQ_ON = 7;
  localparam int XMIT_DONE_IRQ_ON  = 6;
  localparam int RCV_FULL_IRQ_ON   = 5;
  localparam int LINE_QUIET_IRQ_ON = 4;
  localparam int XMIT_ON           = 3;
  localparam int RCV_ON            = 2;
  localparam int RCV_SLEEP_REQUEST = 1;
  localparam int BREAK_QUEUE       = 0;
  localparam int INTERNAL_LOOP_SEL = 0;
  localparam int RCV_SOURCE_SEL    = 1;
  localparam int SINGLE_LINE_DIR   = 2;
  localparam int CHAR_LEN_SEL      = 3;
  localparam int WAKE_SEL          = 4;
  localparam logic [7:0]  CTL2_RESET = 8'h00;
  localparam logic [4:0]  LINE_RESET = 5'h00;
  localparam logic [12:0] BAUD_RESET = 13'h0004;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [3:0]  BITS_8 = 4'ha;
  localparam logic [3:0]  BITS_9 = 4'hb;

  // Bit times in one frame, also the idle-line length.
  function automatic logic [3:0] frame_bits(input logic char9);
    frame_bits = char9 ? BITS_9 : BITS_8;
  endfunction
endpackage

// ### asce_xmit.sv
// Transmit shifter: sends data, idle or break frames LSB first.
// Assumes the caller holds its start requests until the matching took pulse.
`timescale 1ns/1ps
module asce_xmit (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [asce_pkg::CNT_W-1:0] bit_cycles,
  input  wire logic                     char9,
  input  wire logic                     go_brk,
  input  wire logic                     go_idle,
  input  wire logic                     go_data,
  input  wire logic [8:0]               dat,
  output logic                          line,
  output logic                          busy,
  output logic                          took_brk,
  output logic                          took_idle,
  output logic                          took_data
);
  import asce_pkg::*;

  typedef struct packed {
    logic [10:0]      sh;
    logic [3:0]       left;
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             line;
  } asce_xst_t;

  asce_xst_t s_reg, s_next;
  logic [10:0] frame;

  always_comb begin
    s_next    = s_reg;
    took_brk  = 1'b0;
    took_idle = 1'b0;
    took_data = 1'b0;
    frame     = 11'h7ff;
    if (!s_reg.busy) begin
      if (bit_cycles != '0 && (go_brk || go_idle || go_data)) begin
        if (go_brk) begin
          frame    = 11'h000;
          took_brk = 1'b1;
        end else if (go_idle) begin
          took_idle = 1'b1;
        end else begin
          frame     = {1'b1, char9 ? dat[8] : 1'b1, dat[7:0], 1'b0};
          took_data = 1'b1;
        end
        s_next.sh   = frame;
        s_next.line = frame[0];
        s_next.busy = 1'b1;
        s_next.left = frame_bits(char9) - 4'h1;
        s_next.cnt  = bit_cycles - 17'h1;
      end
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 17'h1;
    end else if (s_reg.left == 4'h0) begin
      s_next.busy = 1'b0;
      s_next.line = 1'b1;
    end else begin
      s_next.sh   = {1'b1, s_reg.sh[10:1]};
      s_next.line = s_reg.sh[1];
      s_next.left = s_reg.left - 4'h1;
      s_next.cnt  = bit_cycles - 17'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{sh: 11'h7ff, left: 4'h0, cnt: '0, busy: 1'b0, line: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign line = s_reg.line;
  assign busy = s_reg.busy;
endmodule

// ### asce_top.sv
// Serial control block: control and line registers, receiver, pin steering.
// Assumes an AXI4-Lite master on aclk and GPIO logic that takes unowned pins.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module asce_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [asce_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [asce_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      xmit_pin_in,
  output logic                           xmit_pin_out,
  output logic                           xmit_pin_oe_n,
  output logic                           xmit_pin_own,
  input  wire logic                      rcv_pin_in,
  output logic                           rcv_pin_own,
  output logic                           irq
);
  import asce_pkg::*;

  typedef enum logic [2:0] {
    RX_WAIT  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } asce_rx_t;

  typedef struct packed {
    logic [7:0]        ctl;
    logic [4:0]        cfg;
    logic [12:0]       br;
    logic [8:0]        tbuf;
    logic              xmit_buf_empty_flag;
    logic              rcv_buf_full_flag;
    logic              idle;
    logic [8:0]        rdat;
    logic              brk_pend;
    logic              idle_pend;
    asce_rx_t          rst;
    logic [CNT_W-1:0]  rcnt;
    logic [3:0]        ridx;
    logic [8:0]        rsh;
    logic [CNT_W-1:0]  qcnt;
    logic [3:0]        qbits;
    logic              armed;
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } asce_st_t;

  asce_st_t s_reg, s_next;

  logic             tx_line;
  logic             tx_busy;
  logic             took_brk;
  logic             took_idle;
  logic             took_data;
  logic             tc;
  logic             tx_own;
  logic             loop;
  logic             src;
  logic             rx_in;
  logic             rx_run;
  logic             char9;
  logic [CNT_W-1:0] bitc;
  logic             go_brk;

  assign char9  = s_reg.cfg[CHAR_LEN_SEL];
  assign bitc   = {s_reg.br, 4'h0};
  assign loop   = s_reg.cfg[INTERNAL_LOOP_SEL];
  assign src    = s_reg.cfg[RCV_SOURCE_SEL];
  assign go_brk = s_reg.brk_pend | s_reg.ctl[BREAK_QUEUE];

  asce_xmit u_xmit (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bit_cycles(bitc),
    .char9     (char9),
    .go_brk    (go_brk),
    .go_idle   (s_reg.idle_pend),
    .go_data   (s_reg.ctl[XMIT_ON] & ~s_reg.xmit_buf_empty_flag),
    .dat       (s_reg.tbuf),
    .line      (tx_line),
    .busy      (tx_busy),
    .took_brk  (took_brk),
    .took_idle (took_idle),
    .took_data (took_data)
  );

  // Transmitter stays in charge until everything it queued has gone out.
  assign tx_own = s_reg.ctl[XMIT_ON] | tx_busy | go_brk | s_reg.idle_pend;
  assign tc     = s_reg.xmit_buf_empty_flag & ~tx_busy & ~go_brk & ~s_reg.idle_pend;

  always_comb begin
    xmit_pin_own  = loop ? (src & (tx_own | s_reg.ctl[RCV_ON])) : tx_own;
    xmit_pin_oe_n = ~(tx_own & ~loop |
                      tx_own & loop & src & s_reg.cfg[SINGLE_LINE_DIR]);
    rx_in = loop ? (src ? xmit_pin_in : tx_line) : rcv_pin_in;
  end

  assign xmit_pin_out = tx_line;
  assign rcv_pin_own  = s_reg.ctl[RCV_ON] & ~loop;
  assign rx_run       = s_reg.ctl[RCV_ON] & (s_reg.br != 13'h0000);

  assign irq = (s_reg.ctl[XMIT_EMPTY_IRQ_ON] & s_reg.xmit_buf_empty_flag) |
               (s_reg.ctl[XMIT_DONE_IRQ_ON]  & tc)         |
               (s_reg.ctl[RCV_FULL_IRQ_ON]   & s_reg.rcv_buf_full_flag) |
               (s_reg.ctl[LINE_QUIET_IRQ_ON] & s_reg.idle);

  assign s_axi_awready = ~s_reg.aw_have & ~s_reg.bvalid;
  assign s_axi_wready  = ~s_reg.w_have & ~s_reg.bvalid;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [7:0]        newc;
    logic              rd_data;
    logic              char_done;
    logic              quiet;
    logic              wake_hit;
    wa        = s_reg.awaddr & WORD_MASK;
    ra        = s_axi_araddr & WORD_MASK;
    newc      = s_reg.ctl;
    rd_data   = 1'b0;
    char_done = 1'b0;
    quiet     = 1'b0;
    wake_hit  = 1'b0;
    s_next    = s_reg;

    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_have = 1'b1;
      s_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_have = 1'b1;
      s_next.wdata  = s_axi_wdata;
      s_next.wstrb  = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      unique case (wa)
        OFS_CTL2: begin
          if (s_reg.wstrb[0]) begin
            newc = s_reg.wdata[7:0];
          end
        end
        OFS_LINE: begin
          if (s_reg.wstrb[0]) begin
            s_next.cfg = s_reg.wdata[4:0];
          end
        end
        OFS_STAT: begin
        end
        OFS_DATA: begin
          if (s_reg.wstrb[0]) begin
            s_next.tbuf = {s_reg.wstrb[1] & s_reg.wdata[8], s_reg.wdata[7:0]};
            s_next.xmit_buf_empty_flag = 1'b0;
          end
        end
        OFS_BAUD: begin
          if (s_reg.wstrb[0]) begin
            s_next.br[7:0] = s_reg.wdata[7:0];
          end
          if (s_reg.wstrb[1]) begin
            s_next.br[12:8] = s_reg.wdata[12:8];
          end
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_next.ctl = newc;

    // Rising edges of the enable and the break bit queue idle and break frames.
    if (newc[XMIT_ON] && !s_reg.ctl[XMIT_ON]) begin
      s_next.idle_pend = 1'b1;
    end else if (took_idle) begin
      s_next.idle_pend = 1'b0;
    end
    if (newc[BREAK_QUEUE] && !s_reg.ctl[BREAK_QUEUE]) begin
      s_next.brk_pend = 1'b1;
    end else if (took_brk) begin
      s_next.brk_pend = 1'b0;
    end
    if (took_data) begin
      s_next.xmit_buf_empty_flag = 1'b1;
    end

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      unique case (ra)
        OFS_CTL2: s_next.rdata[7:0] = s_reg.ctl;
        OFS_LINE: s_next.rdata[4:0] = s_reg.cfg;
        OFS_STAT: s_next.rdata[7:4] = {s_reg.xmit_buf_empty_flag, tc, s_reg.rcv_buf_full_flag, s_reg.idle};
        OFS_DATA: begin
          s_next.rdata[8:0] = s_reg.rdat;
          rd_data           = 1'b1;
        end
        OFS_BAUD: s_next.rdata[12:0] = s_reg.br;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end

    unique case (s_reg.rst)
      RX_WAIT: begin
        if (rx_run && !rx_in) begin
          s_next.rst  = RX_START;
          s_next.rcnt = bitc >> 1;
        end
      end
      RX_START: begin
        if (s_reg.rcnt != '0) begin
          s_next.rcnt = s_reg.rcnt - 17'h1;
        end else if (rx_in) begin
          s_next.rst = RX_WAIT;
        end else begin
          s_next.rst  = RX_DATA;
          s_next.rcnt = bitc - 17'h1;
          s_next.ridx = 4'h0;
        end
      end
      RX_DATA: begin
        if (s_reg.rcnt != '0) begin
          s_next.rcnt = s_reg.rcnt - 17'h1;
        end else begin
          s_next.rcnt = bitc - 17'h1;
          if (s_reg.ridx == frame_bits(char9) - 4'h2) begin
            char_done  = 1'b1;
            s_next.rst = RX_WAIT;
          end else begin
            s_next.rsh  = {rx_in, s_reg.rsh[8:1]};
            s_next.ridx = s_reg.ridx + 4'h1;
          end
        end
      end
    endcase
    if (!rx_run) begin
      s_next.rst = RX_WAIT;
    end

    // Idle line: a full frame of high bit times after a received character.
    if (s_reg.rst != RX_WAIT || !rx_in || !rx_run) begin
      s_next.qcnt  = bitc - 17'h1;
      s_next.qbits = 4'h0;
    end else if (s_reg.qcnt != '0) begin
      s_next.qcnt = s_reg.qcnt - 17'h1;
    end else begin
      s_next.qcnt  = bitc - 17'h1;
      s_next.qbits = s_reg.qbits + 4'h1;
      quiet = s_reg.armed && (s_reg.qbits + 4'h1 == frame_bits(char9));
    end

    if (rd_data) begin
      s_next.rcv_buf_full_flag = 1'b0;
      s_next.idle = 1'b0;
    end
    if (quiet) begin
      s_next.armed = 1'b0;
      if (!s_reg.ctl[RCV_SLEEP_REQUEST]) begin
        s_next.idle = 1'b1;
      end else if (!s_reg.cfg[WAKE_SEL]) begin
        wake_hit = 1'b1;
      end
    end
    if (char_done) begin
      s_next.armed = 1'b1;
      if (s_reg.ctl[RCV_SLEEP_REQUEST] && s_reg.cfg[WAKE_SEL] && s_reg.rsh[8]) begin
        wake_hit = 1'b1;
      end
      if (!s_reg.ctl[RCV_SLEEP_REQUEST] || wake_hit) begin
        s_next.rcv_buf_full_flag = 1'b1;
        s_next.rdat = char9 ? s_reg.rsh : {1'b0, s_reg.rsh[8:1]};
      end
    end
    // A software change of the standby bit in the same cycle wins over wakeup.
    if (wake_hit && newc[RCV_SLEEP_REQUEST] == s_reg.ctl[RCV_SLEEP_REQUEST]) begin
      s_next.ctl[RCV_SLEEP_REQUEST] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg          <= '0;
      s_reg.ctl      <= CTL2_RESET;
      s_reg.cfg      <= LINE_RESET;
      s_reg.br       <= BAUD_RESET;
      s_reg.xmit_buf_empty_flag     <= 1'b1;
      s_reg.rst      <= RX_WAIT;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ### asce_top_props.sv
// Checker for the serial control block, watching only its top ports.
// Assumes aclk with the synchronous active-low aresetn.
`timescale 1ns/1ps
module asce_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        xmit_pin_oe_n,
  input wire logic        xmit_pin_own,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_rd_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_drive_owned: assert property (
    !xmit_pin_oe_n |-> xmit_pin_own) else $error("pin driven while not owned");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !irq && xmit_pin_oe_n && !xmit_pin_own && !s_axi_bvalid)
    else $error("outputs busy after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_drive: cover property ($fell(xmit_pin_oe_n));
endmodule

bind asce_top asce_top_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .xmit_pin_oe_n(xmit_pin_oe_n), .xmit_pin_own(xmit_pin_own), .irq(irq));

// ### asce_node.sv
// Remote serial node facing the transmit and receive pins.
// Assumes 8-bit frames and a fixed bit time of BIT aclk cycles.
`timescale 1ns/1ps
module asce_node #(
  parameter int BIT = 16
) (
  input  wire logic aclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Start low, data LSB first, stop high; the line then rests high.
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask

  // Sampling on the falling edge keeps clear of the block's launch edge.
  task automatic get(output logic [7:0] d);
    while (line_in !== 1'b0) @(negedge aclk);
    repeat (BIT / 2) @(negedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge aclk);
      d[i] = line_in;
    end
    @(posedge aclk);
  endtask

  task automatic low_run(output int n);
    n = 0;
    // Looking only at falling edges keeps a run launched at the call's edge whole.
    do @(negedge aclk); while (line_in !== 1'b0);
    while (line_in === 1'b0) begin
      n++;
      @(negedge aclk);
    end
    @(posedge aclk);
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the serial control block and a remote node.
// Assumes a baud divisor of 1, so one bit lasts 16 aclk cycles.
`timescale 1ns/1ps
module testbench;
  import asce_pkg::*;
  logic              aclk = 0;
  logic              aresetn = 0;
  logic [ADDR_W-1:0] awaddr = 0;
  logic [ADDR_W-1:0] araddr = 0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]       wdata = 0, rdata;
  logic [1:0]        bresp, rresp, wresp;
  logic [3:0]        wstrb = 4'hf;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              tx_out, tx_oe_n, tx_own, rx_in, rx_own, irq;
  int                mismatches = 0;
  int                samples_checked = 0;
  // The shared pin has a pull-up when nobody drives it.
  wire               pin = tx_oe_n ? 1'b1 : tx_out;

  always #2.5 aclk = ~aclk;

  asce_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xmit_pin_in(pin), .xmit_pin_out(tx_out),
    .xmit_pin_oe_n(tx_oe_n), .xmit_pin_own(tx_own), .rcv_pin_in(rx_in),
    .rcv_pin_own(rx_own), .irq(irq));
  asce_node #(.BIT(16)) node (.aclk(aclk), .line_in(pin), .line_out(rx_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_CTL2, d, r);
    check("ctl reset", d, {24'h0, CTL2_RESET});
    rd(OFS_STAT, d, r);
    check("flags at reset", d[7:6], 2'b11);
    wr(OFS_CTL2, 32'h30);
    rd(OFS_CTL2, d, r);
    check("ctl readback", d, 32'h30);
    wstrb <= 4'h0;
    wr(OFS_CTL2, 32'hff);
    wstrb <= 4'hf;
    rd(OFS_CTL2, d, r);
    check("strobe off", d, 32'h30);
    rd(5'h14, d, r);
    check("unmapped", r, RESP_SLVERR);
    wr(5'h14, 32'h0);
    check("wr unmapped", wresp, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTL2, 32'h80 >> i);
      check("irq enable", irq, i < 2);
    end
    wr(OFS_CTL2, 32'h0);
    check("irq masked", irq, 1'b0);
    $display("regs done");
  endtask

  task automatic t_tx;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    int          n;
    wr(OFS_BAUD, 32'h1);
    wr(OFS_CTL2, 32'h08);
    check("pin taken", {tx_own, tx_oe_n}, 2'b10);
    rd(OFS_STAT, d, r);
    check("idle queued", d[6], 1'b0);
    wr(OFS_DATA, 32'ha5);
    node.get(c);
    check("frame", c, 8'ha5);
    rd(OFS_STAT, d, r);
    check("buffer empty", d[7], 1'b1);
    wr(OFS_CTL2, 32'h09);
    node.low_run(n);
    check("break 8", n, 160);
    node.low_run(n);
    check("break repeat", n, 160);
    wr(OFS_CTL2, 32'h08);
    repeat (170) @(posedge aclk);
    rd(OFS_STAT, d, r);
    check("breaks stop", d[6], 1'b1);
    wr(OFS_LINE, 32'h08);
    wr(OFS_CTL2, 32'h00);
    wr(OFS_CTL2, 32'h08);
    wr(OFS_CTL2, 32'h09);
    wr(OFS_CTL2, 32'h00);
    check("pin kept", tx_own, 1'b1);
    node.low_run(n);
    check("break 9", n, 176);
    repeat (4) @(posedge aclk);
    check("pin freed", tx_own, 1'b0);
    wr(OFS_CTL2, 32'h08);
    wr(OFS_LINE, 32'h01);
    check("loop frees pin", {tx_own, tx_oe_n}, 2'b01);
    wr(OFS_LINE, 32'h03);
    check("single in", tx_oe_n, 1'b1);
    wr(OFS_LINE, 32'h07);
    check("single out", tx_oe_n, 1'b0);
    wr(OFS_LINE, 32'h0);
    wr(OFS_CTL2, 32'h0);
    $display("tx done");
  endtask

  task automatic t_rx;
    logic [31:0] d;
    logic [1:0]  r;
    check("rx pin free", rx_own, 1'b0);
    wr(OFS_CTL2, 32'h24);
    check("rx pin taken", rx_own, 1'b1);
    node.send(8'h3c);
    check("rx irq", irq, 1'b1);
    rd(OFS_DATA, d, r);
    check("rx char", d, 32'h3c);
    check("rx irq off", irq, 1'b0);
    repeat (180) @(posedge aclk);
    wr(OFS_CTL2, 32'h14);
    check("idle irq", irq, 1'b1);
    wr(OFS_LINE, 32'h10);
    wr(OFS_CTL2, 32'h06);
    node.send(8'h12);
    rd(OFS_CTL2, d, r);
    check("asleep", d, 32'h06);
    node.send(8'h81);
    rd(OFS_CTL2, d, r);
    check("mark wake", d, 32'h04);
    rd(OFS_DATA, d, r);
    check("mark char", d, 32'h81);
    wr(OFS_LINE, 32'h0);
    wr(OFS_CTL2, 32'h06);
    node.send(8'h12);
    repeat (200) @(posedge aclk);
    rd(OFS_CTL2, d, r);
    check("idle wake", d, 32'h04);
    $display("rx done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_tx;
    t_rx;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
